// file: bench/iop_mux_properties.sv
// Purpose: port-level properties of the I/O mux
// Assumes: bound to iop_mux; pins sampled by a 2-flop chain
// Notes:   pin causes are counted from the first sampled level
`timescale 1ns/1ps
`default_nettype none

module iop_mux_props (
  input wire logic                  mclk_i,
  input wire logic                  resetn_i,
  input wire iop_pkg::iop_apb_req_t apb_i,
  input wire iop_pkg::iop_apb_rsp_t apb_o,
  input wire logic [20:0]           pin_in_i,
  input wire logic [20:0]           pin_oe_o,
  input wire logic [2:0]            port_irq_o,
  input wire logic                  port_zero_dma_trigger_o,
  input wire logic                  port_one_dma_trigger_o
);
  import iop_pkg::*;
  wire       wr    = apb_i.psel & apb_i.penable & apb_i.pwrite;
  wire       setup = apb_i.psel & ~apb_i.penable;
  wire [7:0] p0    = pin_in_i[7:0];
  wire [7:0] p1    = pin_in_i[15:8];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence setup_s; apb_i.psel && !apb_i.penable; endsequence
  sequence access_s; apb_i.psel && apb_i.penable; endsequence
  rdy_access_a: assert property (
    setup_s ##1 access_s |-> apb_o.pready) else $error("pready low in access");
  rdata_hold_a: assert property (
    $changed(apb_o.prdata) && $past(resetn_i) |-> $past(setup))
    else $error("read data moved outside setup");
  wr_rdata_a: assert property (
    access_s and apb_i.pwrite |-> apb_o.prdata == 32'h0) else $error("write returned data");
  err_data_a: assert property (
    apb_o.pslverr |-> apb_o.prdata == 32'h0) else $error("error with nonzero data");
  dma0_cause_a: assert property (
    port_zero_dma_trigger_o |-> $past(p0, 3) != $past(p0, 4))
    else $error("port 0 trigger without pin change");
  dma1_cause_a: assert property (
    port_one_dma_trigger_o |-> $past(p1, 3) != $past(p1, 4))
    else $error("port 1 trigger without pin change");
  irq_cause_a: assert property (
    (port_irq_o & ~$past(port_irq_o)) != 3'h0 |->
      $past(wr, 2) || $past(pin_in_i, 4) != $past(pin_in_i, 5))
    else $error("irq rose without cause");
  reset_quiet_a: assert property (@(posedge mclk_i) disable iff (1'b0)
    !resetn_i |=> pin_oe_o == 21'h0 && port_irq_o == 3'h0) else $error("reset left pins driven");
endmodule

`default_nettype wire

// file: bench/iop_pin_dev.sv
// Purpose: far-side device on the 21 pins
// Assumes: every pin has a pull-up
// Notes:   the device yields while the block drives a pin
`timescale 1ns/1ps
`default_nettype none

module iop_pin_dev (
  input  wire logic [20:0] drv_val_i,
  input  wire logic [20:0] drv_en_i,
  input  wire logic [20:0] pin_out_i,
  input  wire logic [20:0] pin_oe_i,
  output wire logic [20:0] pin_lvl_o
);
  // Undriven pins float to 1, never to an unknown
  assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & (~drv_en_i | drv_val_i));
endmodule

`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the I/O mux
// Assumes: pins pulled up by the far-side model
// Notes:   6-cycle waits cover pin sync, flag and irq stages
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.svh"

module tb_top;
  import iop_pkg::*;
  logic          mclk, err;
  logic          resetn = 1'b0;
  iop_apb_req_t  req    = '0;
  iop_apb_rsp_t  rsp;
  iop_ser_drv_t  s0     = '0;
  iop_ser_drv_t  s1     = '0;
  iop_tmr1_drv_t t1     = '0;
  iop_tmr3_drv_t t3     = '0;
  logic [20:0]   dval   = '0;
  logic [20:0]   den    = '0;
  logic [20:0]   lvl, pout, poe;
  logic [2:0]    irq;
  logic          d0, d1;
  logic [3:0]    s0i, s1i;
  logic [2:0]    t1i;
  logic [1:0]    t3i;
  int            mismatches = 0;
  int            n_compared = 0;
  int            c0 = 0;
  int            c1 = 0;

  iop_mux u_iop_mux (.mclk_i(mclk), .resetn_i(resetn), .apb_i(req), .apb_o(rsp),
    .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_o(poe), .ser0_i(s0), .ser1_i(s1),
    .tmr1_i(t1), .tmr3_i(t3), .ser0_in_o(s0i), .ser1_in_o(s1i),
    .tmr1_in_o(t1i), .tmr3_in_o(t3i),
    .port_irq_o(irq), .port_zero_dma_trigger_o(d0), .port_one_dma_trigger_o(d1));
  iop_pin_dev u_iop_pin_dev (.drv_val_i(dval), .drv_en_i(den), .pin_out_i(pout),
    .pin_oe_i(poe), .pin_lvl_o(lvl));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    c0 <= c0 + int'(d0 === 1'b1);
    c1 <= c1 + int'(d1 === 1'b1);
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge mclk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic pin(input logic [20:0] en, input logic [20:0] v);
    @(posedge mclk);
    den <= en;
    dval <= v;
    wt(6);
  endtask

  task automatic t_reset;
    chk(32'(poe), 32'h0);
    rd(`IOP_OFS_SEL0, 32'h0);
    rd(`IOP_OFS_SEL1, 32'h0);
    rd(`IOP_OFS_SEL2, 32'h0);
    rd(8'h40, 32'h0);
    chk(32'(err), 32'h1);
  endtask
  task automatic t_event;
    int b0, b1;
    wr(`IOP_OFS_PEN, 32'h6);
    wr(`IOP_OFS_ECTL, 32'h2A);
    pin(21'h10011, 21'h0);
    rd(`IOP_OFS_FLG0, 32'h0);
    b0 = c0;
    b1 = c1;
    pin(21'h10111, 21'h10011);
    chk(c0 - b0, 1);
    chk(c1 - b1, 1);
    rd(`IOP_OFS_FLG0, 32'h11);
    rd(`IOP_OFS_FLG1, 32'h01);
    rd(`IOP_OFS_FLG2, 32'h01);
    chk(irq, 3'b100);
    wr(`IOP_OFS_PEN, 32'h7);
    wt(2);
    chk(irq, 3'b101);
    wr(`IOP_OFS_FLG0, 32'hFFFFFFFE);
    rd(`IOP_OFS_FLG0, 32'h10);
    chk(irq, 3'b100);
    wr(`IOP_OFS_P1EN, 32'h1);
    wt(2);
    chk(irq, 3'b110);
  endtask
  task automatic t_gate;
    int b0;
    wr(`IOP_OFS_SEL0, 32'h40);
    wr(`IOP_OFS_DIR0, 32'h80);
    b0 = c0;
    pin(21'h040, 21'h0);
    wr(`IOP_OFS_DAT0, 32'h7F);
    // Releasing pin 6 gives it a rising edge while it is a peripheral pin
    pin(21'h0, 21'h0);
    chk(c0 - b0, 0);
    chk({poe[7:6], pout[7]}, 3'b100);
    rd(`IOP_OFS_DAT0, 32'h7F);
    rd(`IOP_OFS_FLG0, 32'h10);
  endtask
  task automatic t_mux;
    @(posedge mclk);
    s0 <= '{4'b0101, 4'hF, 1'b0};
    s1 <= '{4'hF, 4'hF, 1'b0};
    t1 <= '{3'b101, 3'h7};
    wr(`IOP_OFS_SEL0, 32'h3C);
    wt(2);
    chk({poe[5:2], pout[5:2]}, 8'hF9);
    wr(`IOP_OFS_DIR2, 32'h40);
    wt(2);
    chk(pout[5:2], 4'hF);
    wr(`IOP_OFS_DIR2, 32'h80);
    wt(2);
    chk(pout[4:2], 3'b101);
    wr(`IOP_OFS_DIR2, 32'h0);
    s0.uart_no_flow <= 1'b1;
    wt(2);
    chk(pout[5:2], 4'b1101);
    s0.uart_no_flow <= 1'b0;
    wr(`IOP_OFS_LOC, 32'h41);
    wr(`IOP_OFS_SEL1, 32'h3C);
    wt(2);
    chk({poe[13:10], pout[13:10]}, 8'hF6);
    chk(pout[5:2], 4'hF);
    wr(`IOP_OFS_SEL2, 32'h20);
    wt(2);
    chk(pout[10], 1'b1);
    s1.dout <= 4'h0;
    t3 <= '{2'b10, 2'b11};
    wr(`IOP_OFS_LOC, 32'h43);
    wr(`IOP_OFS_SEL2, 32'h100);
    wt(2);
    chk({poe[12], pout[12]}, 2'b10);
    wr(`IOP_OFS_SEL2, 32'h180);
    wt(6);
    chk({poe[12], pout[12]}, 2'b11);
    chk({s0i, s1i}, 8'h5B);
    chk({t1i, t3i}, 5'h1B);
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_reset;
    t_event;
    t_gate;
    t_mux;
    end_sim;
  end
  initial begin
    #100000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim;
  end
endmodule

bind iop_mux iop_mux_props u_iop_mux_props (.mclk_i, .resetn_i, .apb_i, .apb_o, .pin_in_i,
  .pin_oe_o, .port_irq_o, .port_zero_dma_trigger_o, .port_one_dma_trigger_o);

`default_nettype wire

// file: core/iop_mux.sv
// Purpose: GPIO pin events, DMA triggers and peripheral pin mux, APB slave
// Assumes: pins asynchronous to mclk_i; peripherals on mclk_i
// Notes:   pins 0-7 port 0, 8-15 port 1, 16-20 port 2
//
// Contract
// - GPIO input pins raise events on a software-chosen rising or falling edge.
// - One port-level interrupt enable per port gates that port's request.
// - Each port 1 pin has its own enable besides the port enable.
// - Port 0 has one group enable for pins 0-3, one for 4-7.
// - The five port 2 pins share one group enable.
// - A pin event sets that pin's flag to 1 in its port's flag register.
// - Flags set on events even while the pin's enables are cleared.
// - Writing 0 to a flag bit clears that flag.
// - Port 0 and port 1 each have a DMA trigger on input transitions.
// - Only GPIO input pins cause DMA triggers; peripheral or output pins never.
// - A pin carries a peripheral only when its function-select bit is 1.
// - Both serial units and timers 1, 3 have a location-select bit.
// - Priority bits pick which of two peripherals sharing pins drives them.
// - Port 0 priority 00 serial 0, 01 serial 1, 10/11 timer 1.
// - UART without flow control releases its RTS and CTS pins to others.
// - Port 1: serial 0 wins when serial and timer1-serial0 bits are 0.
// - Port 1: serial 1 wins when serial bit 1, timer3-serial1 bit 0.
// - Port 1: timer 1 wins when timer4-timer1 low and timer1-serial0 high.
// - Port 1: timer 3 beats serial 1 when timer3-serial1 bit is set.
// - Timer 1 routes channels 0-2, timer 3 channels 0-1, to its location.
// - Each serial unit routes its four UART or SPI signals to its location.
// - Reset clears every function-select bit; all pins start as GPIO.
// - Location bit 0 selects the first pin set, 1 the second.
`include "iop_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module iop_mux (
  input  wire logic                    mclk_i,
  input  wire logic                    resetn_i,
  input  wire iop_pkg::iop_apb_req_t   apb_i,
  output wire iop_pkg::iop_apb_rsp_t   apb_o,
  input  wire logic [20:0]             pin_in_i,
  output var  logic [20:0]             pin_out_o,
  output var  logic [20:0]             pin_oe_o,
  input  wire iop_pkg::iop_ser_drv_t   ser0_i,
  input  wire iop_pkg::iop_ser_drv_t   ser1_i,
  input  wire iop_pkg::iop_tmr1_drv_t  tmr1_i,
  input  wire iop_pkg::iop_tmr3_drv_t  tmr3_i,
  output var  logic [3:0]              ser0_in_o,
  output var  logic [3:0]              ser1_in_o,
  output var  logic [2:0]              tmr1_in_o,
  output var  logic [1:0]              tmr3_in_o,
  output var  logic [2:0]              port_irq_o,
  output var  logic                    port_zero_dma_trigger_o,
  output var  logic                    port_one_dma_trigger_o
);
  import iop_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [20:0]  pin_meta;
  logic [20:0]  pin_s;
  logic [20:0]  pin_q;
  logic [7:0]   dat0;
  logic [7:0]   dat1;
  logic [4:0]   dat2;
  logic [7:0]   dir0;
  logic [7:0]   dir1;
  logic [4:0]   dir2;
  logic [7:0]   sel0;
  logic [7:0]   sel1;
  logic [4:0]   sel2;
  logic         loc_s0;
  logic         loc_s1;
  logic         loc_t1;
  logic         loc_t3;
  logic [2:0]   edge_fall;
  logic         grp_p0lo;
  logic         grp_p0hi;
  logic         grp_p2;
  logic [7:0]   p1_pin_en;
  logic [7:0]   flg0;
  logic [7:0]   flg1;
  logic [4:0]   flg2;
  logic [2:0]   port_en;
  iop_p0_pri_t  p0_pri;
  logic         pri_t1s0;
  logic         pri_t4t1;
  logic         pri_t3s1;
  logic         pri_ser;
  logic [31:0]  rd_q;
  logic         err_q;
  logic [31:0]  next_rd;
  logic         next_err;
  logic         wr;
  logic [31:0]  wd;
  logic [20:0]  gp_dat;
  logic [20:0]  gp_dir;
  logic [20:0]  gp_sel;
  logic [20:0]  gp_in;
  logic [20:0]  trig;
  logic [20:0]  toggled;
  logic [19:0]  m_s0;
  logic [19:0]  m_s1;
  logic [14:0]  m_t1;
  logic [9:0]   m_t3;
  logic [4:0]   p;
  logic [20:0]  c_s0;
  logic [20:0]  c_s1;
  logic [20:0]  c_t1;
  logic [20:0]  c_t3;
  logic [20:0]  o_s0;
  logic [20:0]  o_s1;
  logic [20:0]  o_t1;
  logic [20:0]  o_t3;
  logic [20:0]  e_s0;
  logic [20:0]  e_s1;
  logic [20:0]  e_t1;
  logic [20:0]  e_t3;
  logic [20:0]  next_pin_out;
  logic [20:0]  next_pin_oe;
  logic         p0_s1o0;
  logic         p0_t1o0;

  assign gp_dat  = {dat2, dat1, dat0};
  assign gp_dir  = {dir2, dir1, dir0};
  assign gp_sel  = {sel2, sel1, sel0};
  assign gp_in   = ~gp_sel & ~gp_dir;
  assign toggled = pin_s ^ pin_q;
  assign wr      = apb_i.psel & apb_i.penable & apb_i.pwrite;
  assign wd      = apb_i.pwdata;

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  // Resets to the pulled-up level so release gives no false edge
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pin_meta <= `IOP_RST_PIN;
      pin_s    <= `IOP_RST_PIN;
      pin_q    <= `IOP_RST_PIN;
    end else begin
      pin_meta <= pin_in_i;
      pin_s    <= pin_meta;
      pin_q    <= pin_s;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------------
  always_comb begin
    next_rd  = 32'h0000_0000;
    next_err = 1'b0;
    unique case (apb_i.paddr)
      `IOP_OFS_DAT0: next_rd[7:0] = pin_s[7:0];
      `IOP_OFS_DAT1: next_rd[7:0] = pin_s[15:8];
      `IOP_OFS_DAT2: next_rd[4:0] = pin_s[20:16];
      `IOP_OFS_DIR0: next_rd[7:0] = dir0;
      `IOP_OFS_DIR1: next_rd[7:0] = dir1;
      `IOP_OFS_DIR2: next_rd[7:0] = {p0_pri, 1'b0, dir2};
      `IOP_OFS_SEL0: next_rd[7:0] = sel0;
      `IOP_OFS_SEL1: next_rd[7:0] = sel1;
      `IOP_OFS_SEL2: next_rd[8:0] = {pri_ser, pri_t3s1, pri_t4t1, pri_t1s0, sel2};
      `IOP_OFS_LOC:  next_rd[7:0] = {1'b0, loc_t1, loc_t3, 3'h0, loc_s1, loc_s0};
      `IOP_OFS_ECTL: next_rd[5:0] = {grp_p2, grp_p0hi, grp_p0lo, edge_fall};
      `IOP_OFS_P1EN: next_rd[7:0] = p1_pin_en;
      `IOP_OFS_FLG0: next_rd[7:0] = flg0;
      `IOP_OFS_FLG1: next_rd[7:0] = flg1;
      `IOP_OFS_FLG2: next_rd[4:0] = flg2;
      `IOP_OFS_PEN:  next_rd[2:0] = port_en;
      default:       next_err     = 1'b1;
    endcase
  end

  // Answer is captured in the setup cycle and stands in the access cycle
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rd_q  <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (apb_i.psel && !apb_i.penable) begin
      rd_q  <= apb_i.pwrite ? 32'h0000_0000 : next_rd;
      err_q <= next_err;
    end
  end

  assign apb_o = '{prdata: rd_q, pready: 1'b1, pslverr: err_q};

  // ----------------------------------------------------------------------
  // GPIO data, direction and function select
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      dat0   <= `IOP_RST_DAT8;
      dat1   <= `IOP_RST_DAT8;
      dat2   <= `IOP_RST_DAT5;
      dir0   <= 8'h00;
      dir1   <= 8'h00;
      dir2   <= 5'h00;
      sel0   <= 8'h00;
      sel1   <= 8'h00;
      sel2   <= 5'h00;
      p0_pri <= IOP_PRI_SER0;
    end else if (wr) begin
      unique case (apb_i.paddr)
        `IOP_OFS_DAT0: dat0 <= wd[7:0];
        `IOP_OFS_DAT1: dat1 <= wd[7:0];
        `IOP_OFS_DAT2: dat2 <= wd[4:0];
        `IOP_OFS_DIR0: dir0 <= wd[7:0];
        `IOP_OFS_DIR1: dir1 <= wd[7:0];
        `IOP_OFS_DIR2: begin
          dir2   <= wd[4:0];
          p0_pri <= iop_p0_pri_t'(wd[`IOP_DIR2_PRI +: 2]);
        end
        `IOP_OFS_SEL0: sel0 <= wd[7:0];
        `IOP_OFS_SEL1: sel1 <= wd[7:0];
        `IOP_OFS_SEL2: sel2 <= wd[4:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Location and priority controls
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      loc_s0   <= 1'b0;
      loc_s1   <= 1'b0;
      loc_t1   <= 1'b0;
      loc_t3   <= 1'b0;
      pri_t1s0 <= 1'b0;
      pri_t4t1 <= 1'b0;
      pri_t3s1 <= 1'b0;
      pri_ser  <= 1'b0;
    end else if (wr && apb_i.paddr == `IOP_OFS_LOC) begin
      loc_s0 <= wd[`IOP_LOC_S0];
      loc_s1 <= wd[`IOP_LOC_S1];
      loc_t1 <= wd[`IOP_LOC_T1];
      loc_t3 <= wd[`IOP_LOC_T3];
    end else if (wr && apb_i.paddr == `IOP_OFS_SEL2) begin
      pri_t1s0 <= wd[`IOP_SEL2_T1S0];
      pri_t4t1 <= wd[`IOP_SEL2_T4T1];
      pri_t3s1 <= wd[`IOP_SEL2_T3S1];
      pri_ser  <= wd[`IOP_SEL2_SER];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt control
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      edge_fall <= 3'h0;
      grp_p0lo  <= 1'b0;
      grp_p0hi  <= 1'b0;
      grp_p2    <= 1'b0;
      p1_pin_en <= 8'h00;
      port_en   <= 3'h0;
    end else if (wr) begin
      unique case (apb_i.paddr)
        `IOP_OFS_ECTL: begin
          edge_fall <= wd[2:0];
          grp_p0lo  <= wd[`IOP_ECTL_GRP0LO];
          grp_p0hi  <= wd[`IOP_ECTL_GRP0HI];
          grp_p2    <= wd[`IOP_ECTL_GRP2];
        end
        `IOP_OFS_P1EN: p1_pin_en <= wd[7:0];
        `IOP_OFS_PEN:  port_en   <= wd[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Edge detection, per pin
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 21; i++) begin : g_evt
    localparam int PT = i / 8;
    assign trig[i] = gp_in[i] & (edge_fall[PT] ? (pin_q[i] & ~pin_s[i])
                                               : (pin_s[i] & ~pin_q[i]));
  end

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  // A new event outranks a clear in the same cycle; enables play no part
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      flg0 <= 8'h00;
      flg1 <= 8'h00;
      flg2 <= 5'h00;
    end else begin
      flg0 <= ((wr && apb_i.paddr == `IOP_OFS_FLG0) ? (flg0 & wd[7:0]) : flg0)
              | trig[7:0];
      flg1 <= ((wr && apb_i.paddr == `IOP_OFS_FLG1) ? (flg1 & wd[7:0]) : flg1)
              | trig[15:8];
      flg2 <= ((wr && apb_i.paddr == `IOP_OFS_FLG2) ? (flg2 & wd[4:0]) : flg2)
              | trig[20:16];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt requests and DMA triggers
  // ----------------------------------------------------------------------
  // Requests follow flags as levels; a write that clears several flags clears them
  // in the same cycle, so the request drops once and the write never re-raises it
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      port_irq_o              <= 3'h0;
      port_zero_dma_trigger_o <= 1'b0;
      port_one_dma_trigger_o  <= 1'b0;
    end else begin
      port_irq_o[0] <= port_en[0] & ((grp_p0lo & |flg0[3:0])
                                   | (grp_p0hi & |flg0[7:4]));
      port_irq_o[1] <= port_en[1] & |(flg1 & p1_pin_en);
      port_irq_o[2] <= port_en[2] & grp_p2 & |flg2;
      port_zero_dma_trigger_o <= |(toggled[7:0] & gp_in[7:0]);
      port_one_dma_trigger_o  <= |(toggled[15:8] & gp_in[15:8]);
    end
  end

  // ----------------------------------------------------------------------
  // Peripheral pin claims
  // ----------------------------------------------------------------------
  assign m_s0 = loc_s0 ? `IOP_S0_MAP2 : `IOP_S0_MAP1;
  assign m_s1 = loc_s1 ? `IOP_S1_MAP2 : `IOP_S1_MAP1;
  assign m_t1 = loc_t1 ? `IOP_T1_MAP2 : `IOP_T1_MAP1;
  assign m_t3 = loc_t3 ? `IOP_T3_MAP2 : `IOP_T3_MAP1;

  always_comb begin
    p    = 5'h00;
    c_s0 = '0;
    c_s1 = '0;
    c_t1 = '0;
    c_t3 = '0;
    o_s0 = '0;
    o_s1 = '0;
    o_t1 = '0;
    o_t3 = '0;
    e_s0 = '0;
    e_s1 = '0;
    e_t1 = '0;
    e_t3 = '0;
    for (int f = 0; f < 4; f++) begin
      p = m_s0[5*f +: 5];
      if (f < 2 || !ser0_i.uart_no_flow) begin
        c_s0[p] = 1'b1;
        o_s0[p] = ser0_i.dout[f];
        e_s0[p] = ser0_i.doe[f];
      end
      p = m_s1[5*f +: 5];
      if (f < 2 || !ser1_i.uart_no_flow) begin
        c_s1[p] = 1'b1;
        o_s1[p] = ser1_i.dout[f];
        e_s1[p] = ser1_i.doe[f];
      end
    end
    for (int f = 0; f < 3; f++) begin
      p = m_t1[5*f +: 5];
      c_t1[p] = 1'b1;
      o_t1[p] = tmr1_i.dout[f];
      e_t1[p] = tmr1_i.doe[f];
    end
    for (int f = 0; f < 2; f++) begin
      p = m_t3[5*f +: 5];
      c_t3[p] = 1'b1;
      o_t3[p] = tmr3_i.dout[f];
      e_t3[p] = tmr3_i.doe[f];
    end
  end

  // ----------------------------------------------------------------------
  // Port 0 priority decode
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (p0_pri)
      IOP_PRI_SER0: begin
        p0_s1o0 = 1'b0;
        p0_t1o0 = 1'b0;
      end
      IOP_PRI_SER1: begin
        p0_s1o0 = 1'b1;
        p0_t1o0 = 1'b0;
      end
      IOP_PRI_TMR1, IOP_PRI_TMR1B: begin
        p0_s1o0 = 1'b0;
        p0_t1o0 = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Arbitration and pin drive, per pin
  // ----------------------------------------------------------------------
  // Conflicts are settled pairwise; a pair with no priority bit keeps
  // the serial unit ahead of the timer, serial 0 ahead of serial 1 and timer 1 ahead of timer 3
  for (genvar i = 0; i < 21; i++) begin : g_pin
    localparam int PT = i / 8;
    logic s1o0;
    logic t1o0;
    logic t1o1;
    logic t3o1;
    logic w_s0;
    logic w_s1;
    logic w_t1;
    logic w_t3;
    if (PT == 0) begin : g_p0
      assign s1o0 = p0_s1o0;
      assign t1o0 = p0_t1o0;
      assign t1o1 = p0_t1o0;
      assign t3o1 = 1'b0;
    end else if (PT == 1) begin : g_p1
      assign s1o0 = pri_ser;
      assign t1o0 = pri_t1s0 & ~pri_t4t1;
      assign t1o1 = 1'b0;
      assign t3o1 = pri_t3s1;
    end else begin : g_p2
      assign s1o0 = 1'b0;
      assign t1o0 = 1'b0;
      assign t1o1 = 1'b0;
      assign t3o1 = 1'b0;
    end
    assign w_s0 = c_s0[i] & ~(c_s1[i] & s1o0) & ~(c_t1[i] & t1o0);
    assign w_s1 = c_s1[i] & ~w_s0 & ~(c_t1[i] & t1o1) & ~(c_t3[i] & t3o1);
    assign w_t1 = c_t1[i] & ~w_s0 & ~w_s1;
    assign w_t3 = c_t3[i] & ~w_s0 & ~w_s1 & ~w_t1;
    always_comb begin
      if (!gp_sel[i]) begin
        next_pin_out[i] = gp_dat[i];
        next_pin_oe[i]  = gp_dir[i];
      end else if (w_s0) begin
        next_pin_out[i] = o_s0[i];
        next_pin_oe[i]  = e_s0[i];
      end else if (w_s1) begin
        next_pin_out[i] = o_s1[i];
        next_pin_oe[i]  = e_s1[i];
      end else if (w_t1) begin
        next_pin_out[i] = o_t1[i];
        next_pin_oe[i]  = e_t1[i];
      end else begin
        next_pin_out[i] = o_t3[i];
        next_pin_oe[i]  = e_t3[i] & w_t3;
      end
    end
  end

  // Registered drive adds one cycle, equal on every pin, so SPI and
  // timer edges keep their relative timing
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pin_out_o <= `IOP_RST_PIN;
      pin_oe_o  <= 21'h000000;
    end else begin
      pin_out_o <= next_pin_out;
      pin_oe_o  <= next_pin_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Peripheral inputs from the selected location
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ser0_in_o <= 4'hF;
      ser1_in_o <= 4'hF;
      tmr1_in_o <= 3'h7;
      tmr3_in_o <= 2'h3;
    end else begin
      for (int f = 0; f < 4; f++) begin
        ser0_in_o[f] <= pin_s[m_s0[5*f +: 5]];
        ser1_in_o[f] <= pin_s[m_s1[5*f +: 5]];
      end
      for (int f = 0; f < 3; f++) begin
        tmr1_in_o[f] <= pin_s[m_t1[5*f +: 5]];
      end
      for (int f = 0; f < 2; f++) begin
        tmr3_in_o[f] <= pin_s[m_t3[5*f +: 5]];
      end
    end
  end

endmodule

`default_nettype wire

// file: pkg/iop_defs.svh
// Purpose: offsets, field positions, reset values and pin maps of the I/O mux
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef IOP_DEFS_SVH
`define IOP_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IOP_OFS_DAT0 8'h00
`define IOP_OFS_DAT1 8'h04
`define IOP_OFS_DAT2 8'h08
`define IOP_OFS_DIR0 8'h0C
`define IOP_OFS_DIR1 8'h10
`define IOP_OFS_DIR2 8'h14
`define IOP_OFS_SEL0 8'h18
`define IOP_OFS_SEL1 8'h1C
`define IOP_OFS_SEL2 8'h20
`define IOP_OFS_LOC  8'h24
`define IOP_OFS_ECTL 8'h28
`define IOP_OFS_P1EN 8'h2C
`define IOP_OFS_FLG0 8'h30
`define IOP_OFS_FLG1 8'h34
`define IOP_OFS_FLG2 8'h38
`define IOP_OFS_PEN  8'h3C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IOP_LOC_S0    0
`define IOP_LOC_S1    1
`define IOP_LOC_T3    5
`define IOP_LOC_T1    6
`define IOP_ECTL_GRP0LO 3
`define IOP_ECTL_GRP0HI 4
`define IOP_ECTL_GRP2   5
`define IOP_DIR2_PRI  6
`define IOP_SEL2_T1S0 5
`define IOP_SEL2_T4T1 6
`define IOP_SEL2_T3S1 7
`define IOP_SEL2_SER  8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IOP_RST_DAT8 8'hFF
`define IOP_RST_DAT5 5'h1F
`define IOP_RST_PIN  21'h1FFFFF

// ----------------------------------------------------------------------
// Pin maps, five bits per function, function 0 lowest
// ----------------------------------------------------------------------
`define IOP_S0_MAP1 {5'h04, 5'h05, 5'h03, 5'h02}
`define IOP_S0_MAP2 {5'h0A, 5'h0B, 5'h0D, 5'h0C}
`define IOP_S1_MAP1 {5'h02, 5'h03, 5'h04, 5'h05}
`define IOP_S1_MAP2 {5'h0C, 5'h0D, 5'h0E, 5'h0F}
`define IOP_T1_MAP1 {5'h04, 5'h03, 5'h02}
`define IOP_T1_MAP2 {5'h08, 5'h09, 5'h0A}
`define IOP_T3_MAP1 {5'h0C, 5'h0B}
`define IOP_T3_MAP2 {5'h0F, 5'h0E}

`endif

// file: pkg/iop_pkg.sv
// Purpose: types shared by the I/O mux and its bench
// Assumes: nothing
// Notes:   constants live in iop_defs.svh
package iop_pkg;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } iop_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } iop_apb_rsp_t;

  // Functions 0..3: RX/MISO, TX/MOSI, RTS/SCK, CTS/SSN
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] doe;
    logic       uart_no_flow;
  } iop_ser_drv_t;

  typedef struct packed {
    logic [2:0] dout;
    logic [2:0] doe;
  } iop_tmr1_drv_t;

  typedef struct packed {
    logic [1:0] dout;
    logic [1:0] doe;
  } iop_tmr3_drv_t;

  typedef enum logic [1:0] {
    IOP_PRI_SER0  = 2'b00,
    IOP_PRI_SER1  = 2'b01,
    IOP_PRI_TMR1  = 2'b10,
    IOP_PRI_TMR1B = 2'b11
  } iop_p0_pri_t;

endpackage
